// ==== pkg/wdog_defs.svh ====
// Field positions, reset values, window limits and timing counts of the watchdog
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

// ***************************************************
// Service register fields
// ***************************************************
`define WD_WIN_MSB        7
`define WD_WIN_LSB        6
`define WD_KEY_MSB        5
`define WD_KEY_LSB        1
`define WD_CM_BIT         0
`define WD_KEY_VALUE      5'h0c
`define WD_KEY_READ       5'h00

// ***************************************************
// Reset values
// ***************************************************
`define WD_RESET_WIN      2'h3
`define WD_RESET_CM       1'h1

// ***************************************************
// Window limits in idle-timer clocks
// ***************************************************
`define LOWER_LIMIT_LOGIC_LIMIT    17'h00800
`define UPPER_LIMIT_LOGIC_BASE     17'h02000

// ***************************************************
// Fault hold and clock monitor timing
// ***************************************************
`define WD_HOLD_TICKS     5'h10
`define CM_RECOVER_TICKS  5'h10
`define SYS_CLK_MHZ       200
`define CM_LIMIT_US       1000
`define CM_LIMIT_CYCLES   (`CM_LIMIT_US * `SYS_CLK_MHZ)

`endif

// ==== pkg/wdog_pkg.sv ====
// Types shared by the watchdog design
package wdog_pkg;

   // Watchdog fault sequencing states
   typedef enum logic [1:0] {
      WD_RUN,
      WD_DRIVE,
      WD_HOLD,
      WD_WAIT_HIGH
   } wd_state_t;

endpackage : wdog_pkg

// ==== logic/clock_rate_detector.sv ====
// Slow instruction clock detector for the clock monitor
`timescale 1ns/1ps
`include "wdog_defs.svh"

module clock_rate_detector #(
   parameter int unsigned LIMIT_CYCLES = `CM_LIMIT_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // Instruction cycle pulse
   input  wire logic instr_tick,
   // Rate error level
   output logic      slow_r
);

   logic [19:0] gap_r;
   logic [4:0]  good_r;
   logic        gap_full;

   // Gap reached the rejection limit
   assign gap_full = (gap_r == LIMIT_CYCLES[19:0]);

   // ***************************************************
   // Gap between instruction cycles
   // ***************************************************

   // Counts system clocks since the last instruction cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_r <= 20'h00000;
      end else if (instr_tick) begin
         gap_r <= 20'h00000;
      end else if (!gap_full) begin
         gap_r <= gap_r + 20'h00001;
      end
   end

   // ***************************************************
   // Error flag and recovery
   // ***************************************************

   // Flags a dead or slow clock, clears after good cycles
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         slow_r <= 1'b0;
         good_r <= 5'h00;
      end else if (gap_full) begin
         slow_r <= 1'b1;
         good_r <= 5'h00;
      end else if (slow_r && instr_tick) begin
         if (good_r == `CM_RECOVER_TICKS - 5'h01) begin
            slow_r <= 1'b0;
            good_r <= 5'h00;
         end else begin
            good_r <= good_r + 5'h01;
         end
      end
   end

endmodule : clock_rate_detector

// ==== logic/windowed_watchdog_clock_monitor.sv ====
// Windowed watchdog with clock monitor and fault pin control
//
// Functional notes
// - Service bits 7:6 pick upper limit 8k, 16k, 32k or 64k idle clocks.
// - Lower window limit fixed at 2048 idle-timer clocks.
// - Key field bits 5:1 must hold 01100 for an accepted service.
// - Service bit 0 enables the clock monitor when set.
// - Watchdog exists only when option bit 2 is low; pin is fault output.
// - Inactive in reset; afterwards armed, maximum window, monitor enabled.
// - First keyed write after reset fixes window and monitor enable.
// - Later writes must match every stored bit, else a watchdog error.
// - Fully matching write is valid and restarts window timing.
// - No valid service before the upper limit raises an error.
// - Service before the lower limit since last service is an error.
// - Boot ROM entry suppresses lower error and services immediately.
// - Error drives pin low, holds 16-32 cycles after pin reads low.
// - Window timing restarts when the fault pin returns high.
// - Writes while the fault output is held are ignored.
// - Pin stuck low at power-up: watchdog times out, then releases.
// - Monitor drives pin low while clock slow; releases after 16-32 cycles.
// - Never flags clocks at or above 5 kHz; always flags below 10 Hz.
// - Timing in instruction cycles or 32 kHz cycles per clock mode.
// - Watchdog timing suspended in halt and idle; monitor stays active.
// - Leaving idle performs a hardware service.
// - Reading the service register returns zero in the key field.
`timescale 1ns/1ps
`include "wdog_defs.svh"

module windowed_watchdog_clock_monitor #(
   parameter int unsigned CM_LIMIT_CYCLES = `CM_LIMIT_CYCLES
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // Service register access
   input  wire logic       svc_wr,
   input  wire logic [7:0] svc_wdata,
   output logic      [7:0] service_register_r,
   // Option strap, low enables the watchdog
   input  wire logic       option_wd_disable,
   // Timing sources
   input  wire logic       instr_tick,
   input  wire logic       lowspeed_clk_in,
   input  wire logic       high_speed_mode,
   // Power modes and boot ROM
   input  wire logic       halt_mode,
   input  wire logic       idle_mode,
   input  wire logic       boot_rom_active,
   // Fault output pin, open drain
   input  wire logic       fault_output_pin_in,
   output logic            fault_output_pin_out_r,
   output logic            fault_output_pin_oe_r,
   // Status
   output logic            wd_error_r
);

   // ***************************************************
   // Declarations
   // ***************************************************
   wdog_pkg::wd_state_t state_r;
   wdog_pkg::wd_state_t state_nxt;
   logic [1:0]  win_sel_r;
   logic        cm_en_r;
   logic        first_done_r;
   logic [16:0] elapsed_r;
   logic [16:0] upper_limit;
   logic [4:0]  hold_r;
   logic        pin_meta_r;
   logic        pin_sync_r;
   logic        ls_meta_r;
   logic        ls_sync_r;
   logic        ls_prev_r;
   logic        idle_prev_r;
   logic        boot_prev_r;
   logic        idle_tick;
   logic        ls_rise;
   logic        idle_exit;
   logic        boot_entry;
   logic        hw_service;
   logic        wd_active;
   logic        wr_taken;
   logic        key_ok;
   logic        all_ok;
   logic        too_early;
   logic        timeout;
   logic        svc_valid;
   logic        svc_error;
   logic        cm_slow;
   logic        hold_done;
   logic        wd_drive;
   logic        cm_drive;

   // ***************************************************
   // Pin synchronisers
   // ***************************************************

   // Fault pin level seen through the input threshold
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
      end else begin
         pin_meta_r <= fault_output_pin_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Low-speed 32 kHz clock brought into the system domain
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ls_meta_r <= 1'b0;
         ls_sync_r <= 1'b0;
         ls_prev_r <= 1'b0;
      end else begin
         ls_meta_r <= lowspeed_clk_in;
         ls_sync_r <= ls_meta_r;
         ls_prev_r <= ls_sync_r;
      end
   end

   // ***************************************************
   // Idle-timer clock and hardware services
   // ***************************************************

   // Rising edge of the synchronised 32 kHz clock
   assign ls_rise = ls_sync_r && !ls_prev_r;

   // Instruction cycles in high speed, else 32 kHz rising edges
   assign idle_tick = high_speed_mode ? instr_tick : ls_rise;

   // Edge history for idle exit and boot ROM entry
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         idle_prev_r <= 1'b0;
         boot_prev_r <= 1'b0;
      end else begin
         idle_prev_r <= idle_mode;
         boot_prev_r <= boot_rom_active;
      end
   end

   // Idle exit and boot ROM entry as one-cycle events
   assign idle_exit  = idle_prev_r && !idle_mode;
   assign boot_entry = boot_rom_active && !boot_prev_r;

   // Either event restarts the window like a valid write
   assign hw_service = idle_exit || boot_entry;

   // Watchdog present only with the option bit low
   assign wd_active = !option_wd_disable;

   // ***************************************************
   // Window limits
   // ***************************************************

   // Upper limit doubles with each window code
   assign upper_limit = `UPPER_LIMIT_LOGIC_BASE << win_sel_r;

   // Elapsed count at or past the selected upper limit
   assign timeout = (elapsed_r >= upper_limit);

   // Lower limit, waived in boot ROM and for the first write
   assign too_early = first_done_r && !boot_rom_active
                    && (elapsed_r < `LOWER_LIMIT_LOGIC_LIMIT);

   // ***************************************************
   // Service write checks
   // ***************************************************

   // Writes count only in the run state with the pin released
   assign wr_taken = svc_wr && wd_active
                   && (state_r == wdog_pkg::WD_RUN)
                   && !fault_output_pin_oe_r;

   // Key field compare
   assign key_ok = (svc_wdata[`WD_KEY_MSB:`WD_KEY_LSB]
                    == `WD_KEY_VALUE);

   // Every field against the stored choices
   assign all_ok = key_ok
                 && (svc_wdata[`WD_WIN_MSB:`WD_WIN_LSB] == win_sel_r)
                 && (svc_wdata[`WD_CM_BIT] == cm_en_r);

   // Valid service: key on first write, all fields later
   assign svc_valid = wr_taken && !too_early
                    && (first_done_r ? all_ok : key_ok);

   // Any other taken write is an error
   assign svc_error = wr_taken && !svc_valid;

   // ***************************************************
   // Stored window and monitor choices
   // ***************************************************

   // Captured once by the first keyed write after reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         win_sel_r    <= `WD_RESET_WIN;
         cm_en_r      <= `WD_RESET_CM;
         first_done_r <= 1'b0;
      end else if (svc_valid && !first_done_r) begin
         win_sel_r    <= svc_wdata[`WD_WIN_MSB:`WD_WIN_LSB];
         cm_en_r      <= svc_wdata[`WD_CM_BIT];
         first_done_r <= 1'b1;
      end
   end

   // ***************************************************
   // Elapsed time counter
   // ***************************************************

   // Counts idle clocks while running, frozen in halt and idle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         elapsed_r <= 17'h00000;
      end else if (svc_valid || hw_service) begin
         elapsed_r <= 17'h00000;
      end else if (state_r == wdog_pkg::WD_WAIT_HIGH) begin
         if (pin_sync_r) begin
            elapsed_r <= 17'h00000;
         end
      end else if (state_r == wdog_pkg::WD_RUN && idle_tick
                   && !halt_mode && !idle_mode && !timeout) begin
         elapsed_r <= elapsed_r + 17'h00001;
      end
   end

   // ***************************************************
   // Fault sequencing
   // ***************************************************

   // Next state of the watchdog fault sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         wdog_pkg::WD_RUN: begin
            if (wd_active && (svc_error || timeout)) begin
               state_nxt = wdog_pkg::WD_DRIVE;
            end
         end
         wdog_pkg::WD_DRIVE: begin
            if (!pin_sync_r) begin
               state_nxt = wdog_pkg::WD_HOLD;
            end
         end
         wdog_pkg::WD_HOLD: begin
            if (hold_done) begin
               state_nxt = wdog_pkg::WD_WAIT_HIGH;
            end
         end
         wdog_pkg::WD_WAIT_HIGH: begin
            if (pin_sync_r) begin
               state_nxt = wdog_pkg::WD_RUN;
            end
         end
         default: begin
            state_nxt = wdog_pkg::WD_RUN;
         end
      endcase
   end

   // State register, WD_RUN in reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= wdog_pkg::WD_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Hold counter in instruction cycles after the pin reads low
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_r <= 5'h00;
      end else if (state_r != wdog_pkg::WD_HOLD) begin
         hold_r <= 5'h00;
      end else if (instr_tick) begin
         hold_r <= hold_r + 5'h01;
      end
   end

   // Last counted instruction cycle of the hold
   assign hold_done = instr_tick && (hold_r == `WD_HOLD_TICKS - 5'h01);

   // ***************************************************
   // Clock monitor
   // ***************************************************

   // Rate detector runs in every power mode
   clock_rate_detector #(
      .LIMIT_CYCLES (CM_LIMIT_CYCLES)
   ) u_rate (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .instr_tick (instr_tick),
      .slow_r     (cm_slow)
   );

   // ***************************************************
   // Fault pin drive
   // ***************************************************

   // Fault sequence pulls the pin until its hold ends
   assign wd_drive = (state_nxt == wdog_pkg::WD_DRIVE)
                   || (state_nxt == wdog_pkg::WD_HOLD);

   // Slow clock pulls the pin only with the monitor enabled
   assign cm_drive = cm_en_r && cm_slow;

   // Open drain: value always low, enable pulls the pin down
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_output_pin_out_r <= 1'b0;
         fault_output_pin_oe_r  <= 1'b0;
      end else begin
         fault_output_pin_out_r <= 1'b0;
         fault_output_pin_oe_r  <= wd_active && (wd_drive || cm_drive);
      end
   end

   // Watchdog fault in progress, visible as status
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_error_r <= 1'b0;
      end else begin
         wd_error_r <= (state_nxt != wdog_pkg::WD_RUN);
      end
   end

   // ***************************************************
   // Service register read back
   // ***************************************************

   // Window and monitor bits read true, key always zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         service_register_r <= {`WD_RESET_WIN, `WD_KEY_READ, `WD_RESET_CM};
      end else begin
         service_register_r <= {win_sel_r, `WD_KEY_READ, cm_en_r};
      end
   end

endmodule : windowed_watchdog_clock_monitor

// ==== testbench/wdog_checker_assertions.sv ====
// Port checker for the windowed watchdog
`timescale 1ns/1ps

module wdog_checker #(
   parameter int unsigned CM_LIMIT_CYCLES = 200
) (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       reset_n,
   // Service register access
   input wire logic       svc_wr,
   input wire logic [7:0] svc_wdata,
   input wire logic [7:0] service_register_r,
   // Option, timing and power inputs
   input wire logic       option_wd_disable,
   input wire logic       instr_tick,
   input wire logic       lowspeed_clk_in,
   input wire logic       high_speed_mode,
   input wire logic       halt_mode,
   input wire logic       idle_mode,
   input wire logic       boot_rom_active,
   // Fault pin and status
   input wire logic       fault_output_pin_in,
   input wire logic       fault_output_pin_out_r,
   input wire logic       fault_output_pin_oe_r,
   input wire logic       wd_error_r
);
   localparam int GAP_LIM = int'(CM_LIMIT_CYCLES) + 3;
   int gap_r;
   int hold_r;

   // Cycles since the last instruction tick
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) gap_r <= 0;
      else if (instr_tick) gap_r <= 0;
      else if (gap_r < GAP_LIM + 4) gap_r <= gap_r + 1;
   end

   // Ticks spent holding the pin once it reads low
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) hold_r <= 0;
      else if (!fault_output_pin_oe_r) hold_r <= 0;
      else if (wd_error_r && !fault_output_pin_in && instr_tick && hold_r < 63) hold_r <= hold_r + 1;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // ***************************************************
   // Assertions
   // ***************************************************
   a_pin_data_low: assert property (fault_output_pin_out_r == 1'b0)
      else $error("pin data not low");
   a_key_hidden: assert property (service_register_r[5:1] == 5'h00)
      else $error("key field readable");
   a_reset_state: assert property ($rose(reset_n) |-> service_register_r == 8'hc1 && !fault_output_pin_oe_r)
      else $error("bad state after reset");
   a_bad_key_err: assert property (svc_wr && svc_wdata[5:1] != 5'h0c && !option_wd_disable && !wd_error_r
      |=> fault_output_pin_oe_r) else $error("bad key not flagged");
   a_error_drives: assert property ($rose(wd_error_r) |-> ##1 fault_output_pin_oe_r[*8])
      else $error("error pulse too short");
   a_hold_bound: assert property (hold_r <= 34)
      else $error("pin held too long");
   a_restart_high: assert property ($fell(wd_error_r) |-> $past(fault_output_pin_in))
      else $error("restart with pin low");
   a_option_quiet: assert property ($rose(wd_error_r) |-> !$past(option_wd_disable))
      else $error("error while disabled");
   a_cm_gated: assert property ($rose(fault_output_pin_oe_r) && !service_register_r[0] |-> ##[0:1] wd_error_r)
      else $error("monitor drove pin while off");
   a_cm_slow: assert property (gap_r == GAP_LIM && service_register_r[0] && !option_wd_disable
      |-> fault_output_pin_oe_r) else $error("slow clock not flagged");
   a_hold_min: assert property ($fell(fault_output_pin_oe_r) && wd_error_r |-> hold_r >= 16)
      else $error("pin released too early");
   a_held_ignored: assert property (svc_wr && fault_output_pin_oe_r && !wd_error_r |=> !wd_error_r)
      else $error("write taken while pin held");

   // Main scenarios reached
   c_wd_error: cover property ($rose(wd_error_r));
   c_cm_fault: cover property (fault_output_pin_oe_r && !wd_error_r);
   c_valid_svc: cover property (svc_wr && !wd_error_r ##3 !wd_error_r);
endmodule : wdog_checker

bind windowed_watchdog_clock_monitor wdog_checker #(.CM_LIMIT_CYCLES(CM_LIMIT_CYCLES)) u_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .svc_wr(svc_wr), .svc_wdata(svc_wdata),
   .service_register_r(service_register_r), .option_wd_disable(option_wd_disable), .instr_tick(instr_tick),
   .lowspeed_clk_in(lowspeed_clk_in), .high_speed_mode(high_speed_mode), .halt_mode(halt_mode),
   .idle_mode(idle_mode), .boot_rom_active(boot_rom_active), .fault_output_pin_in(fault_output_pin_in),
   .fault_output_pin_out_r(fault_output_pin_out_r), .fault_output_pin_oe_r(fault_output_pin_oe_r),
   .wd_error_r(wd_error_r));

// ==== testbench/fault_pin_partner.sv ====
// Open-drain fault pin with pull-up and optional slow fall
`timescale 1ns/1ps

module fault_pin_partner (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // Design side of the pin
   input  wire logic pin_oe,
   input  wire logic pin_out,
   // Heavy load on the line
   input  wire logic slow_fall,
   // Resolved pin level
   output logic      pin_level
);
   logic [1:0] fall_r;

   // Cycles of drive, a loaded line falls late
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) fall_r <= 2'h0;
      else if (!pin_oe) fall_r <= 2'h0;
      else if (fall_r != 2'h3) fall_r <= fall_r + 2'h1;
   end

   // Weak pull-up wins when nobody drives
   assign pin_level = (pin_oe && (!slow_fall || fall_r == 2'h3)) ? pin_out : 1'b1;
endmodule : fault_pin_partner

// ==== testbench/windowed_watchdog_clock_monitor_tb_top.sv ====
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps

module windowed_watchdog_clock_monitor_tb_top;
   typedef struct {int gap; logic [7:0] data; logic err;} row_t;
   logic       sys_clk = 1'b0, reset_n = 1'b0, svc_wr = 1'b0, option_wd_disable = 1'b0;
   logic       instr_tick = 1'b1, high_speed_mode = 1'b1, halt_mode = 1'b0, idle_mode = 1'b0;
   logic       boot_rom_active = 1'b0, slow_fall = 1'b0, ls_clk = 1'b0, pin_level;
   logic [7:0] svc_wdata = 8'h00, service_register_r;
   logic       fault_output_pin_out_r, fault_output_pin_oe_r, wd_error_r;
   int         errors = 0, check_count = 0;
   // Valid, early, bad key, bad window, bad monitor bit, valid
   row_t rows[6] = '{'{2100, 8'h19, 1'b0}, '{100, 8'h19, 1'b1}, '{2100, 8'h1d, 1'b1},
                     '{2100, 8'h59, 1'b1}, '{2100, 8'h18, 1'b1}, '{2100, 8'h19, 1'b0}};

   always #2.5 sys_clk = ~sys_clk;

   windowed_watchdog_clock_monitor #(.CM_LIMIT_CYCLES(200)) DUT (
      .sys_clk(sys_clk), .reset_n(reset_n), .svc_wr(svc_wr), .svc_wdata(svc_wdata),
      .service_register_r(service_register_r), .option_wd_disable(option_wd_disable),
      .instr_tick(instr_tick), .lowspeed_clk_in(ls_clk), .high_speed_mode(high_speed_mode),
      .halt_mode(halt_mode), .idle_mode(idle_mode), .boot_rom_active(boot_rom_active),
      .fault_output_pin_in(pin_level), .fault_output_pin_out_r(fault_output_pin_out_r),
      .fault_output_pin_oe_r(fault_output_pin_oe_r), .wd_error_r(wd_error_r));

   fault_pin_partner u_pin (.sys_clk(sys_clk), .reset_n(reset_n), .pin_oe(fault_output_pin_oe_r),
      .pin_out(fault_output_pin_out_r), .slow_fall(slow_fall), .pin_level(pin_level));

   // ***************************************************
   // Tasks
   // ***************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   // One-cycle service write, entered at a falling edge
   task automatic wr(input logic [7:0] d);
      svc_wdata = d;
      svc_wr = 1'b1;
      cyc(1);
      svc_wr = 1'b0;
   endtask : wr

   // Wait for the fault sequence to finish
   task automatic recover();
      int i;
      i = 0;
      while ((wd_error_r !== 1'b0 || fault_output_pin_oe_r !== 1'b0) && i < 300) begin
         cyc(1);
         i++;
      end
      if (i >= 300) errors++;
      cyc(4);
   endtask : recover

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // Hang guard, well past the planned run
   initial begin
      #450000;
      errors++;
      end_of_test();
   end

   // ***************************************************
   // Scenarios
   // ***************************************************
   initial begin
      cyc(4);
      check("sreg_rst", service_register_r, 8'hc1);
      reset_n = 1'b1;
      wr(8'h19);
      cyc(2);
      check("sreg_first", service_register_r, 8'h01);
      foreach (rows[i]) begin
         slow_fall = i[0];
         cyc(rows[i].gap);
         wr(rows[i].data);
         cyc(3);
         check("row_err", {7'h0, wd_error_r}, {7'h0, rows[i].err});
         recover();
      end
      cyc(8150);
      check("before_upper", {7'h0, wd_error_r}, 8'h00);
      cyc(40);
      check("upper_8k", {7'h0, wd_error_r}, 8'h01);
      recover();
      halt_mode = 1'b1;
      cyc(9000);
      check("halt_frozen", {7'h0, wd_error_r}, 8'h00);
      halt_mode = 1'b0;
      high_speed_mode = 1'b0;
      cyc(9000);
      check("ls_frozen", {7'h0, wd_error_r}, 8'h00);
      repeat (2250) begin
         ls_clk = 1'b1;
         cyc(1);
         ls_clk = 1'b0;
         cyc(1);
      end
      wr(8'h19);
      cyc(3);
      check("ls_count", {7'h0, wd_error_r}, 8'h00);
      high_speed_mode = 1'b1;
      boot_rom_active = 1'b1;
      cyc(5);
      wr(8'h19);
      cyc(3);
      check("boot_early", {7'h0, wd_error_r}, 8'h00);
      boot_rom_active = 1'b0;
      cyc(2100);
      wr(8'h19);
      cyc(1000);
      idle_mode = 1'b1;
      cyc(5);
      idle_mode = 1'b0;
      cyc(1500);
      wr(8'h19);
      cyc(3);
      check("idle_exit_svc", {7'h0, wd_error_r}, 8'h01);
      recover();
      instr_tick = 1'b0;
      cyc(260);
      check("cm_slow", {6'h0, fault_output_pin_oe_r, fault_output_pin_out_r}, 8'h02);
      wr(8'h1d);
      cyc(3);
      check("held_ignored", {7'h0, wd_error_r}, 8'h00);
      instr_tick = 1'b1;
      cyc(40);
      check("cm_release", {7'h0, fault_output_pin_oe_r}, 8'h00);
      option_wd_disable = 1'b1;
      wr(8'h00);
      cyc(3);
      check("opt_off", {6'h0, wd_error_r, fault_output_pin_oe_r}, 8'h00);
      option_wd_disable = 1'b0;
      reset_n = 1'b0;
      cyc(2);
      check("sreg_rst2", service_register_r, 8'hc1);
      reset_n = 1'b1;
      wr(8'h58);
      cyc(2);
      check("sreg_cm_off", service_register_r, 8'h40);
      instr_tick = 1'b0;
      cyc(260);
      check("cm_off", {7'h0, fault_output_pin_oe_r}, 8'h00);
      instr_tick = 1'b1;
      cyc(8300);
      check("win16k_open", {7'h0, wd_error_r}, 8'h00);
      cyc(8100);
      check("win16k_end", {7'h0, wd_error_r}, 8'h01);
      end_of_test();
   end
endmodule : windowed_watchdog_clock_monitor_tb_top
